// File: hw/sarb_pkg.sv
// Constants and types shared by the symmetric arbiter and its stall tracker
package sarb_pkg;
  localparam int N_AGENTS = 4;
  localparam logic [1:0] RP_RESET = 2'h3;
  // Clock counts, all in bus clocks
  localparam logic [2:0] BNR_FIRST_SAMPLE = 3'h2;
  localparam logic [2:0] BNR_SAMPLE_PERIOD = 3'h2;
  localparam int ADS_TO_BNR = 3;
  localparam logic [2:0] RESET_HOLD = 3'h2;
  localparam logic [2:0] AGENT0_HOLD = 3'h3;
  localparam logic [2:0] BUS_INITIALIZE_HOLD = 3'h4;
  localparam logic [2:0] ADDRESS_ERROR_HOLD = 3'h4;
  localparam logic [2:0] ADDRESS_ERROR_LOCK_OFF = 3'h2;
  localparam logic [2:0] MIN_OFF = 3'h1;
  // Positions in the synchroniser vector
  localparam int SY_RST = 8;
  localparam int SY_BUS_INITIALIZE = 7;
  localparam int SY_ADDRESS_ERROR = 6;
  localparam int SY_BNR = 5;
  localparam int SY_ADS = 4;
  localparam int SY_W = 9;
  localparam logic [SY_W-1:0] SY_IDLE = 9'h1FF;

  typedef enum logic [1:0] {
    SARB_STALLED,
    SARB_THROTTLED,
    SARB_FREE
  } sarb_stall_e;

  typedef enum logic {
    SARB_IDLE,
    SARB_BUSY
  } sarb_own_e;
endpackage

// File: hw/sarb_stall_if.sv
// Signals between the arbiter top and the request stall tracker
interface sarb_stall_if;
  logic rst_evt;
  logic bnr_seen;
  logic ads_seen;
  sarb_pkg::sarb_stall_e state;
  logic may_issue;

  modport ctl (
    output rst_evt,
    output bnr_seen,
    output ads_seen,
    input state,
    input may_issue
  );

  modport stall (
    input rst_evt,
    input bnr_seen,
    input ads_seen,
    output state,
    output may_issue
  );
endinterface

// File: hw/sarb_stall.sv
// Request stall state machine: stalled, throttled and free
module sarb_stall (
  input wire logic clk_i,
  input wire logic nrst_i,
  sarb_stall_if.stall st
);
  sarb_pkg::sarb_stall_e state_q;
  logic [2:0] cnt_q;
  logic [sarb_pkg::ADS_TO_BNR-1:0] ads_dly_q;
  logic used_q;
  logic samp;

  // Sample point: counter while not free, third clock after a strobe when free
  always_comb begin
    samp = (state_q == sarb_pkg::SARB_FREE) ? ads_dly_q[sarb_pkg::ADS_TO_BNR-1] : (cnt_q == 3'h1);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= sarb_pkg::BNR_FIRST_SAMPLE + 3'h1;
    end else if (st.rst_evt) begin
      cnt_q <= sarb_pkg::BNR_FIRST_SAMPLE + 3'h1;
    end else if (state_q != sarb_pkg::SARB_FREE && samp) begin
      cnt_q <= sarb_pkg::BNR_SAMPLE_PERIOD;
    end else if (state_q == sarb_pkg::SARB_FREE && samp && st.bnr_seen) begin
      cnt_q <= sarb_pkg::BNR_SAMPLE_PERIOD;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ads_dly_q <= '0;
    end else if (st.rst_evt) begin
      ads_dly_q <= '0;
    end else begin
      ads_dly_q <= {ads_dly_q[sarb_pkg::ADS_TO_BNR-2:0], st.ads_seen};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= sarb_pkg::SARB_STALLED;
    end else if (st.rst_evt) begin
      state_q <= sarb_pkg::SARB_STALLED;
    end else if (samp) begin
      unique case (state_q)
        sarb_pkg::SARB_STALLED: begin
          state_q <= st.bnr_seen ? sarb_pkg::SARB_STALLED : sarb_pkg::SARB_THROTTLED;
        end
        sarb_pkg::SARB_THROTTLED: begin
          state_q <= st.bnr_seen ? sarb_pkg::SARB_STALLED : sarb_pkg::SARB_FREE;
        end
        sarb_pkg::SARB_FREE: begin
          state_q <= st.bnr_seen ? sarb_pkg::SARB_STALLED : sarb_pkg::SARB_FREE;
        end
        default: begin
          state_q <= sarb_pkg::SARB_STALLED;
        end
      endcase
    end
  end

  // Throttled allows a single strobe until the next sample
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      used_q <= 1'b0;
    end else if (state_q != sarb_pkg::SARB_THROTTLED) begin
      used_q <= 1'b0;
    end else if (st.ads_seen) begin
      used_q <= 1'b1;
    end
  end

  assign st.state = state_q;
  assign st.may_issue = (state_q == sarb_pkg::SARB_FREE) || (state_q == sarb_pkg::SARB_THROTTLED && !used_q);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_STALL_INIT: assert property (st.rst_evt |=> state_q == sarb_pkg::SARB_STALLED)
    else $error("stall state not initialised by reset");
  // A strobe issued while throttled may legally bring a free-state sample right after
  AST_SAMPLE_EVERY_TWO: assert property (samp && state_q != sarb_pkg::SARB_FREE && !st.rst_evt
    |=> !samp || state_q == sarb_pkg::SARB_FREE)
    else $error("block-next-request sampled on adjacent clocks");
  AST_STALL_RELEASE: assert property (samp && state_q == sarb_pkg::SARB_STALLED
    && !st.bnr_seen && !st.rst_evt |=> state_q == sarb_pkg::SARB_THROTTLED)
    else $error("stalled did not move to throttled");
  AST_THROTTLE_ONE: assert property (state_q == sarb_pkg::SARB_THROTTLED && used_q |-> !st.may_issue)
    else $error("second issue allowed while throttled");
  AST_THROTTLE_BACK: assert property (samp && state_q == sarb_pkg::SARB_THROTTLED
    && st.bnr_seen && !st.rst_evt |=> state_q == sarb_pkg::SARB_STALLED && !st.may_issue)
    else $error("throttled did not return to stalled");
  // Empty strobe pipe first: an older strobe may still bring a legal sample
  AST_FREE_QUIET: assert property (state_q == sarb_pkg::SARB_FREE && ads_dly_q == '0 && !st.rst_evt
    && !st.ads_seen ##1 !st.rst_evt && !st.ads_seen ##1 !st.rst_evt
    |=> state_q == sarb_pkg::SARB_FREE [*1])
    else $error("free state left without a strobe");
  AST_FREE_STALL: assert property (state_q == sarb_pkg::SARB_FREE && st.ads_seen && !st.rst_evt
    ##3 (st.bnr_seen && !st.rst_evt) |=> state_q == sarb_pkg::SARB_STALLED ##1 samp)
    else $error("free state missed block-next-request after strobe");
endmodule

// File: hw/sarb_top.sv
// Symmetric bus agent: request stall tracking and rotating-priority ownership
// Operation
// - On bus reset, release block-next-request and initialise stall state to stalled.
// - Block-next-request may rise the clock after reset release; first sampled two later.
// - Stalled or throttled: sample block-next-request every second clock.
// - Stalled: asserted sample stays; deasserted moves to throttled, one transaction allowed.
// - Throttled: asserted sample returns to stalled; deasserted moves to free.
// - Free: sample only three clocks after each address strobe.
// - Free: asserted sample returns to stalled; strobe in that clock is the last.
// - Bus reset or bus-init: drop own request line within one or two clocks.
// - Enabled address error: drop own request line in the next clock.
// - Any reset condition: priority pointer to three, ownership idle.
// - After bus-init, request lines stay off and unsampled for four clocks.
// - After bus reset, request lines stay off and unsampled for two clocks.
// - Agent zero waits at least three clocks after reset release before requesting.
// - After address error stay off four clocks; locked owner reasserts after two.
// - Once asserted, own request holds until this agent becomes owner.
// - From idle pick highest-priority requester, next clock update pointer and busy.
// - Owner may park; dropping with no other requester gives idle, pointer kept.
// - Owner drop with requesters: grant highest priority, next clock update pointer.
// - Owner in a locked sequence keeps its request to hold the bus.
// - A dropped request line stays off at least one clock.
module sarb_top #(
  parameter logic [1:0] AGENT_ID = 2'h0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic bus_reset_n_i,
  input wire logic bus_initialize_n_i,
  input wire logic address_error_n_i,
  input wire logic address_error_obs_en_i,
  input wire logic block_next_request_n_i,
  input wire logic address_strobe_n_i,
  input wire logic [sarb_pkg::N_AGENTS-1:0] symmetric_request_lines_n_i,
  input wire logic core_req_i,
  input wire logic core_lock_i,
  input wire logic core_need_init_i,
  output logic block_next_request_o,
  output logic block_next_request_oe_n_o,
  output logic agent_request_line_o,
  output logic agent_request_line_oe_n_o,
  output logic issue_ok_o,
  output sarb_pkg::sarb_stall_e stall_state_o,
  output logic bus_busy_o,
  output logic owner_o,
  output logic [1:0] priority_pointer_o
);
  localparam logic [sarb_pkg::N_AGENTS-1:0] OWN_MASK = 4'h1 << AGENT_ID;

  sarb_stall_if st_if ();

  logic [sarb_pkg::SY_W-1:0] sync1_q;
  logic [sarb_pkg::SY_W-1:0] sync2_q;
  logic rst_seen;
  logic bus_initialize_seen;
  logic address_error_ev;
  logic arb_rst;
  logic ads_seen;
  logic [sarb_pkg::N_AGENTS-1:0] req;
  logic rst_prev_q;
  logic rst_fall;
  logic bnr_oe_n_q;
  logic bnr_out_q;
  logic breq_oe_n_q;
  logic breq_out_q;
  logic [2:0] blk_q;
  logic [2:0] arb_hold_q;
  logic relock_q;
  logic served_q;
  logic rel_q;
  logic lk_first_q;
  logic lk_later_q;
  logic [1:0] rp_q;
  sarb_pkg::sarb_own_e own_q;
  logic pend_q;
  logic [1:0] win_q;
  logic issue_q;
  logic owner_me;
  logic others;
  logic own_ads;
  logic drop;

  // Highest-priority requester, counting up from one above the pointer
  function automatic logic [1:0] pick(input logic [3:0] r, input logic [1:0] p);
    logic [1:0] c;
    pick = p;
    for (int i = sarb_pkg::N_AGENTS; i >= 1; i--) begin
      c = p + 2'(i);
      if (r[c]) begin
        pick = c;
      end
    end
  endfunction

  // Every bus pin passes two flops; all timing below counts from the second
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= sarb_pkg::SY_IDLE;
      sync2_q <= sarb_pkg::SY_IDLE;
    end else begin
      sync1_q <= {bus_reset_n_i, bus_initialize_n_i, address_error_n_i, block_next_request_n_i,
                  address_strobe_n_i, symmetric_request_lines_n_i};
      sync2_q <= sync1_q;
    end
  end

  always_comb begin
    rst_seen = !sync2_q[sarb_pkg::SY_RST];
    bus_initialize_seen = !sync2_q[sarb_pkg::SY_BUS_INITIALIZE];
    address_error_ev = !sync2_q[sarb_pkg::SY_ADDRESS_ERROR] && address_error_obs_en_i;
    arb_rst = rst_seen || bus_initialize_seen || address_error_ev;
    ads_seen = !sync2_q[sarb_pkg::SY_ADS];
    req = ~sync2_q[sarb_pkg::N_AGENTS-1:0];
    rst_fall = rst_prev_q && !rst_seen;
    owner_me = own_q == sarb_pkg::SARB_BUSY && !pend_q && rp_q == AGENT_ID;
    others = |(req & ~OWN_MASK);
    own_ads = ads_seen && owner_me;
    // Unlocked holding is limited to one transaction when others wait
    drop = !breq_oe_n_q && owner_me && !relock_q && !rel_q
      && (!core_req_i || (others && !core_lock_i && served_q));
  end

  assign st_if.rst_evt = rst_seen || bus_initialize_seen;
  assign st_if.bnr_seen = !sync2_q[sarb_pkg::SY_BNR];
  assign st_if.ads_seen = ads_seen;

  sarb_stall u_stall (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .st(st_if.stall)
  );

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_prev_q <= 1'b0;
    end else begin
      rst_prev_q <= rst_seen;
    end
  end

  // Block-next-request: open drain, only ever pulled low
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bnr_oe_n_q <= 1'b1;
      bnr_out_q <= 1'b0;
    end else if (rst_seen) begin
      bnr_oe_n_q <= 1'b1;
    end else if (rst_fall || !bnr_oe_n_q) begin
      bnr_oe_n_q <= !core_need_init_i;
    end
  end

  // Clocks the own request line must stay off
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blk_q <= sarb_pkg::RESET_HOLD;
    end else if (rst_seen) begin
      blk_q <= (AGENT_ID == 2'h0) ? sarb_pkg::AGENT0_HOLD : sarb_pkg::RESET_HOLD;
    end else if (bus_initialize_seen) begin
      blk_q <= sarb_pkg::BUS_INITIALIZE_HOLD;
    end else if (address_error_ev) begin
      blk_q <= lk_later_q ? sarb_pkg::ADDRESS_ERROR_LOCK_OFF - 3'h1 : sarb_pkg::ADDRESS_ERROR_HOLD;
    end else if (drop) begin
      blk_q <= sarb_pkg::MIN_OFF;
    end else if (blk_q != 3'h0) begin
      blk_q <= blk_q - 3'h1;
    end
  end

  // Clocks the request lines are ignored by the arbiter
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arb_hold_q <= sarb_pkg::RESET_HOLD;
    end else if (rst_seen) begin
      arb_hold_q <= sarb_pkg::RESET_HOLD;
    end else if (bus_initialize_seen) begin
      arb_hold_q <= sarb_pkg::BUS_INITIALIZE_HOLD;
    end else if (address_error_ev) begin
      // Sync pipe still shows the requests the error just removed
      arb_hold_q <= sarb_pkg::RESET_HOLD;
    end else if (arb_hold_q != 3'h0) begin
      arb_hold_q <= arb_hold_q - 3'h1;
    end
  end

  // Own request line
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      breq_oe_n_q <= 1'b1;
      breq_out_q <= 1'b0;
    end else if (arb_rst) begin
      breq_oe_n_q <= 1'b1;
    end else if (drop) begin
      breq_oe_n_q <= 1'b1;
    end else if (breq_oe_n_q && blk_q == 3'h0 && (core_req_i || relock_q)) begin
      breq_oe_n_q <= 1'b0;
    end
  end

  // Locked owner past its first transaction must win the bus back
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      relock_q <= 1'b0;
    end else if (address_error_ev && lk_later_q) begin
      relock_q <= 1'b1;
    end else if (rst_seen || bus_initialize_seen || !breq_oe_n_q) begin
      relock_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lk_first_q <= 1'b0;
      lk_later_q <= 1'b0;
    end else if (!core_lock_i) begin
      lk_first_q <= 1'b0;
      lk_later_q <= 1'b0;
    end else if (own_ads) begin
      lk_first_q <= 1'b1;
      lk_later_q <= lk_first_q || lk_later_q;
    end
  end

  // Our view of ownership lags the wires; a released owner must not drop or issue again
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rel_q <= 1'b0;
    end else if (!owner_me) begin
      rel_q <= 1'b0;
    end else if (drop) begin
      rel_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      served_q <= 1'b0;
    end else if (!owner_me) begin
      served_q <= 1'b0;
    end else if (own_ads) begin
      served_q <= 1'b1;
    end
  end

  // Ownership: every agent runs the same copy on the same samples
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rp_q <= sarb_pkg::RP_RESET;
      own_q <= sarb_pkg::SARB_IDLE;
      pend_q <= 1'b0;
      win_q <= sarb_pkg::RP_RESET;
    end else if (arb_rst) begin
      rp_q <= sarb_pkg::RP_RESET;
      own_q <= sarb_pkg::SARB_IDLE;
      pend_q <= 1'b0;
    end else if (pend_q) begin
      rp_q <= win_q;
      own_q <= sarb_pkg::SARB_BUSY;
      pend_q <= 1'b0;
    end else if (arb_hold_q == 3'h0) begin
      unique case (own_q)
        sarb_pkg::SARB_IDLE: begin
          if (|req) begin
            win_q <= pick(req, rp_q);
            pend_q <= 1'b1;
          end
        end
        sarb_pkg::SARB_BUSY: begin
          if (!req[rp_q] && |req) begin
            win_q <= pick(req, rp_q);
            pend_q <= 1'b1;
          end else if (!req[rp_q]) begin
            own_q <= sarb_pkg::SARB_IDLE;
          end
        end
      endcase
    end
  end

  // Issue only as owner, with the stall state allowing it and a quiet strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      issue_q <= 1'b0;
    end else begin
      issue_q <= owner_me && !rel_q && st_if.may_issue && !ads_seen && core_req_i && !arb_rst;
    end
  end

  assign block_next_request_o = bnr_out_q;
  assign block_next_request_oe_n_o = bnr_oe_n_q;
  assign agent_request_line_o = breq_out_q;
  assign agent_request_line_oe_n_o = breq_oe_n_q;
  assign issue_ok_o = issue_q;
  assign stall_state_o = st_if.state;
  assign bus_busy_o = own_q == sarb_pkg::SARB_BUSY;
  assign owner_o = owner_me;
  assign priority_pointer_o = rp_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_idle_req;
    own_q == sarb_pkg::SARB_IDLE && !pend_q && |req && !arb_rst && arb_hold_q == 3'h0;
  endsequence

  sequence s_owner_gone;
    own_q == sarb_pkg::SARB_BUSY && !pend_q && !req[rp_q] && !arb_rst && arb_hold_q == 3'h0;
  endsequence

  AST_BNR_RELEASE: assert property (rst_seen |=> bnr_oe_n_q)
    else $error("block-next-request driven during reset");
  AST_BNR_LATE: assert property ($fell(bnr_oe_n_q) |-> $past(rst_fall) || !$past(bnr_oe_n_q, 2))
    else $error("block-next-request asserted outside the reset release clock");
  AST_RST_DROP: assert property (rst_seen || bus_initialize_seen |=> breq_oe_n_q)
    else $error("request line not dropped on reset");
  AST_ADDRESS_ERROR_DROP: assert property (address_error_ev |=> breq_oe_n_q)
    else $error("request line not dropped on address error");
  AST_RST_RP: assert property (arb_rst |=> rp_q == sarb_pkg::RP_RESET && own_q == sarb_pkg::SARB_IDLE)
    else $error("pointer or ownership not reinitialised");
  AST_BUS_INITIALIZE_HOLD: assert property ($fell(bus_initialize_seen) && !rst_seen |-> breq_oe_n_q [*4])
    else $error("request line asserted too soon after bus-init");
  AST_RESET_HOLD: assert property (rst_fall |-> breq_oe_n_q [*3])
    else $error("request line asserted too soon after reset");
  AST_HOLD_UNTIL_OWNER: assert property (!breq_oe_n_q && !owner_me && !arb_rst |=> !breq_oe_n_q)
    else $error("request line dropped before ownership");
  AST_IDLE_PICK: assert property (s_idle_req ##1 !arb_rst
    |=> own_q == sarb_pkg::SARB_BUSY && rp_q == $past(win_q))
    else $error("idle arbitration did not complete in two clocks");
  AST_PARK_IDLE: assert property (s_owner_gone ##0 !(|req)
    |=> own_q == sarb_pkg::SARB_IDLE && $stable(rp_q))
    else $error("release without requesters did not idle");
  AST_BUSY_HANDOVER: assert property (s_owner_gone ##0 (|req) ##1 !arb_rst
    |=> own_q == sarb_pkg::SARB_BUSY && rp_q == $past(win_q))
    else $error("busy handover did not update pointer");
  AST_MIN_OFF: assert property ($rose(breq_oe_n_q) |=> breq_oe_n_q)
    else $error("request line reasserted without an off clock");
endmodule

// File: bench/sarb_bus_model.sv
// Far side of the bus: other agents, system logic and wired-OR pins
module sarb_bus_model (
  input wire logic clk_i,
  input wire logic bus_reset_n_i,
  input wire logic [3:1] want_i,
  input wire logic bnr_want_i,
  input wire logic own_req_oe_n_i,
  input wire logic own_bnr_oe_n_i,
  output logic [3:0] req_lines_n_o,
  output logic bnr_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:1] other_q;
  logic bnr_q;
  logic rst_d1_q;
  logic cfg_q;

  // Other agents follow the bench, which holds a line through that agent's ownership
  always_ff @(posedge clk_i) begin
    other_q <= want_i & {3{bus_reset_n_i}};
  end

  // Stall line released while bus reset is active
  always_ff @(posedge clk_i) begin
    bnr_q <= bnr_want_i & bus_reset_n_i;
  end

  // Configuration drive on line zero, dropped a clock after reset is seen gone
  always_ff @(posedge clk_i) begin
    rst_d1_q <= bus_reset_n_i;
    cfg_q <= ~rst_d1_q;
  end

  // Pulled-up open-drain wires
  assign req_lines_n_o = {~other_q, ~(cfg_q | ~own_req_oe_n_i)};
  assign bnr_n_o = ~(bnr_q | ~own_bnr_oe_n_i);
endmodule

// File: bench/sarb_top_test.sv
// Self-checking bench of the symmetric arbiter agent
module sarb_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, brst_n, bus_initialize_n, address_error_n, address_error_en, ads_n, creq, clock_i, cinit, bnr_want;
  logic [3:1] want;
  logic [3:0] lines_n;
  logic bnr_n, bnr_oe_n, req_oe_n, issue_ok, busy, owner;
  logic [1:0] ptr;
  sarb_pkg::sarb_stall_e st;
  int err_total;
  int n_checks;

  sarb_top i_sarb_top (.clk_i(clk), .nrst_i(nrst), .bus_reset_n_i(brst_n), .bus_initialize_n_i(bus_initialize_n),
    .address_error_n_i(address_error_n), .address_error_obs_en_i(address_error_en), .block_next_request_n_i(bnr_n),
    .address_strobe_n_i(ads_n), .symmetric_request_lines_n_i(lines_n), .core_req_i(creq),
    .core_lock_i(clock_i), .core_need_init_i(cinit), .block_next_request_o(),
    .block_next_request_oe_n_o(bnr_oe_n), .agent_request_line_o(), .agent_request_line_oe_n_o(req_oe_n),
    .issue_ok_o(issue_ok), .stall_state_o(st), .bus_busy_o(busy), .owner_o(owner), .priority_pointer_o(ptr));

  sarb_bus_model i_sarb_bus_model (.clk_i(clk), .bus_reset_n_i(brst_n), .want_i(want), .bnr_want_i(bnr_want),
    .own_req_oe_n_i(req_oe_n), .own_bnr_oe_n_i(bnr_oe_n), .req_lines_n_o(lines_n), .bnr_n_o(bnr_n));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic cond(input int c);
    case (c)
      0: return st === sarb_pkg::SARB_THROTTLED;
      1: return st === sarb_pkg::SARB_FREE;
      2: return st === sarb_pkg::SARB_STALLED;
      3: return owner === 1'b1;
      4: return req_oe_n === 1'b1;
      5: return req_oe_n === 1'b0;
      6: return issue_ok === 1'b1;
      default: return ptr === 2'h1;
    endcase
  endfunction

  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_for(input int c, input int lim);
    int k;
    k = 0;
    while (!cond(c) && k < lim) begin
      cyc(1);
      k++;
    end
    n_checks++;
    if (!cond(c)) begin
      err_total++;
      $display("ERROR t=%0t wait %h gave up after %h", $time, c, lim);
      give_verdict();
    end
  endtask

  task automatic strobe();
    wait_for(6, 20);
    ads_n = 1'b0;
    cyc(1);
    ads_n = 1'b1;
  endtask

  task automatic t_reset();
    chk(st, sarb_pkg::SARB_STALLED);
    chk(ptr, 2'h3);
    chk({busy, req_oe_n, bnr_oe_n}, 3'h3);
    creq = 1'b1;
    cyc(4);
    chk(req_oe_n, 1'b1);
    brst_n = 1'b1;
    cinit = 1'b1;
    for (int i = 0; i < 5; i++) begin
      cyc(1);
      chk(req_oe_n, 1'b1);
    end
    chk(bnr_oe_n, 1'b0);
    cinit = 1'b0;
    wait_for(3, 20);
    chk(bnr_oe_n, 1'b1);
    chk({busy, ptr}, 3'h4);
    chk(issue_ok, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_stall();
    for (int i = 0; i < 10; i++) begin
      cyc(1);
      chk(st, sarb_pkg::SARB_STALLED);
    end
    bnr_want = 1'b0;
    wait_for(0, 8);
    wait_for(1, 8);
    bnr_want = 1'b1;
    for (int i = 0; i < 12; i++) begin
      cyc(1);
      chk(st, sarb_pkg::SARB_FREE);
    end
    strobe();
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      chk(st, sarb_pkg::SARB_FREE);
    end
    wait_for(2, 6);
    bnr_want = 1'b0;
    wait_for(1, 16);
    $display("test stall done");
  endtask

  task automatic t_exchange();
    want[1] = 1'b1;
    wait_for(4, 10);
    cyc(1);
    chk(req_oe_n, 1'b1);
    wait_for(7, 6);
    chk(busy, 1'b1);
    wait_for(5, 6);
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      chk({owner, req_oe_n}, 2'h0);
    end
    want[1] = 1'b0;
    wait_for(3, 10);
    clock_i = 1'b1;
    want[2] = 1'b1;
    strobe();
    for (int i = 0; i < 10; i++) begin
      cyc(1);
      chk({owner, req_oe_n}, 2'h2);
    end
    clock_i = 1'b0;
    strobe();
    wait_for(4, 10);
    wait_for(5, 6);
    want[2] = 1'b0;
    wait_for(3, 16);
    $display("test exchange done");
  endtask

  task automatic t_resets();
    address_error_n = 1'b0;
    cyc(1);
    address_error_n = 1'b1;
    wait_for(4, 3);
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      chk({busy, ptr, req_oe_n}, 4'h7);
    end
    wait_for(3, 20);
    bus_initialize_n = 1'b0;
    wait_for(4, 5);
    cyc(2);
    chk({busy, ptr}, 3'h3);
    bus_initialize_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      chk(req_oe_n, 1'b1);
    end
    wait_for(3, 20);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      chk({owner, ptr}, 3'h4);
    end
    creq = 1'b0;
    wait_for(4, 6);
    cyc(3);
    chk({busy, ptr}, 3'h0);
    $display("test resets done");
  endtask

  initial begin
    err_total = 0;
    n_checks = 0;
    {nrst, brst_n, creq, clock_i, cinit, want} = '0;
    {bus_initialize_n, address_error_n, address_error_en, ads_n, bnr_want} = '1;
    cyc(12);
    nrst = 1'b1;
    cyc(1);
    t_reset();
    t_stall();
    t_exchange();
    t_resets();
    give_verdict();
  end
endmodule
